// >>> design/cpu_exception_status_regs.sv
`timescale 1ns/1ns

// Function
// - Error-class exceptions set error level bit
// - Error level blocks interrupts, selects error return
// - Other exceptions set exception level bit
// - Exception level routes refills to general vector
// - Return address frozen while exception level set
// - Interrupt needs enable, both levels clear, mask
// - Privilege decode; levels force kernel mode
// - Three independent 64-bit enables per mode
// - Address space permission follows operating mode
// - Reset forces error level and bootstrap select
// - Soft reset or NMI sets soft flag
// - Bootstrap select picks vector locations
// - Parity disable suppresses parity exceptions
// - Only software pending bits writable in cause
// - Delay slot flag tracks last general exception
// - Coprocessor unusable records coprocessor number
// - Exception code encoding as listed
// - Return address is faulting or branch address
// - TLB miss loads page pair and region
// - Index load tag loads parity override
// - Check-bit override substitutes stored parity
// - Override bits hold even byte/word parity
// - Low pending bits software, upper six external
module cpu_exception_status_regs (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [63:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [63:0] reg_rdata_out,
  input wire logic exc_take_in,
  input wire exc_status_pkg::exc_kind_t exc_kind_in,
  input wire logic [4:0] exc_code_in,
  input wire logic exc_in_delay_in,
  input wire logic [63:0] exc_pc_in,
  input wire logic [63:0] exc_branch_pc_in,
  input wire logic [1:0] exc_cop_in,
  input wire logic tlb_miss_in,
  input wire logic [63:0] exc_vaddr_in,
  input wire logic exc_return_in,
  input wire logic [5:0] ext_int_in,
  input wire logic parity_err_in,
  input wire logic index_load_tag_in,
  input wire logic tag_op_data_in,
  input wire logic [63:0] cache_dword_in,
  output logic int_request_out,
  output logic kernel_mode_out,
  output logic super_mode_out,
  output logic user_mode_out,
  output logic addr64_out,
  output logic ops64_out,
  output logic kernel_space_ok_out,
  output logic super_space_ok_out,
  output logic user_space_ok_out,
  output logic useg_unmapped_out,
  output logic return_uses_error_pc_out,
  output logic refill_general_vector_out,
  output logic vector_bootstrap_out,
  output logic parity_exc_out,
  output logic parity_override_active_out,
  output logic [7:0] parity_override_out
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  // The release is synchronised so that every register leaves reset on the same edge.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [31:0] processor_status_r;
  logic [31:0] exception_cause_r;
  logic [63:0] exception_return_pc_r;
  logic [63:0] extended_pte_pointer_r;
  logic [7:0] cache_parity_override_r;
  logic [7:0] parity_calc;
  logic [31:0] status_nxt;
  logic error_class;
  logic is_wr_status;
  logic exception_level_bit;
  logic error_level_bit;
  logic [1:0] privilege_mode_field;
  logic kernel;
  logic sup_mode;
  logic user;

  assign exception_level_bit = processor_status_r[exc_status_pkg::ST_EXL];
  assign error_level_bit = processor_status_r[exc_status_pkg::ST_ERL];
  assign privilege_mode_field = processor_status_r[exc_status_pkg::ST_KSU_LO +: 2];
  assign error_class = exc_take_in && (exc_kind_in != exc_status_pkg::KIND_GENERAL);
  assign is_wr_status = reg_wr_in && (reg_addr_in == exc_status_pkg::REG_STATUS);

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  always_comb begin
    status_nxt = processor_status_r;
    if (is_wr_status) begin
      status_nxt = reg_wdata_in[31:0] & exc_status_pkg::ST_WMASK;
    end
    if (exc_return_in) begin
      if (error_level_bit) begin
        status_nxt[exc_status_pkg::ST_ERL] = 1'b0;
      end else begin
        status_nxt[exc_status_pkg::ST_EXL] = 1'b0;
      end
    end
    // Hardware events win over a software write in the same cycle.
    if (error_class) begin
      status_nxt[exc_status_pkg::ST_ERL] = 1'b1;
      if (exc_kind_in != exc_status_pkg::KIND_CACHE_ERR) begin
        status_nxt[exc_status_pkg::ST_BEV] = 1'b1;
        status_nxt[exc_status_pkg::ST_SRF] = 1'b1;
      end
    end else if (exc_take_in) begin
      status_nxt[exc_status_pkg::ST_EXL] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      processor_status_r <= exc_status_pkg::ST_RESET;
    end else begin
      processor_status_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Cause register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      exception_cause_r <= 32'h0000_0000;
    end else begin
      exception_cause_r[exc_status_pkg::CA_IP_LO + 2 +: 6] <= ext_int_in;
      if (reg_wr_in && (reg_addr_in == exc_status_pkg::REG_CAUSE)) begin
        exception_cause_r[exc_status_pkg::CA_IP_LO +: 2] <= reg_wdata_in[exc_status_pkg::CA_IP_LO +: 2];
      end
      if (exc_take_in && (exc_kind_in == exc_status_pkg::KIND_GENERAL)) begin
        exception_cause_r[exc_status_pkg::CA_BD] <= exc_in_delay_in;
        exception_cause_r[exc_status_pkg::CA_CODE_LO +: 5] <= exc_code_in;
        if (exc_code_in == exc_status_pkg::EXC_COP_UNUSABLE) begin
          exception_cause_r[exc_status_pkg::CA_CE_LO +: 2] <= exc_cop_in;
        end else begin
          exception_cause_r[exc_status_pkg::CA_CE_LO +: 2] <= 2'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Exception return address
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      exception_return_pc_r <= 64'h0000_0000_0000_0000;
    end else if (exc_take_in && (exc_kind_in == exc_status_pkg::KIND_GENERAL) && !exception_level_bit) begin
      exception_return_pc_r <= exc_in_delay_in ? exc_branch_pc_in : exc_pc_in;
    end else if (reg_wr_in && (reg_addr_in == exc_status_pkg::REG_EPC)) begin
      exception_return_pc_r <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------------
  // Extended page-table pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      extended_pte_pointer_r <= 64'h0000_0000_0000_0000;
    end else begin
      if (reg_wr_in && (reg_addr_in == exc_status_pkg::REG_XCTX)) begin
        extended_pte_pointer_r[63:exc_status_pkg::XC_BASE_LO] <= reg_wdata_in[63:exc_status_pkg::XC_BASE_LO];
      end
      if (exc_take_in && tlb_miss_in) begin
        extended_pte_pointer_r[exc_status_pkg::XC_VPN_HI:exc_status_pkg::XC_VPN_LO] <= exc_vaddr_in[39:13];
        extended_pte_pointer_r[exc_status_pkg::XC_R_LO +: 2] <= exc_vaddr_in[63:62];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cache parity override
  // ----------------------------------------------------------------------
  // Even parity: each bit makes its byte or word carry an even count of ones.
  always_comb begin
    parity_calc = 8'h00;
    if (tag_op_data_in) begin
      for (int i = 0; i < 8; i++) begin
        parity_calc[i] = ^cache_dword_in[8*i +: 8];
      end
    end else begin
      parity_calc[0] = ^cache_dword_in[31:0];
      parity_calc[1] = ^cache_dword_in[63:32];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cache_parity_override_r <= 8'h00;
    end else if (index_load_tag_in) begin
      cache_parity_override_r <= parity_calc;
    end else if (reg_wr_in && (reg_addr_in == exc_status_pkg::REG_PARITY)) begin
      cache_parity_override_r <= reg_wdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_out <= 64'h0000_0000_0000_0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        exc_status_pkg::REG_STATUS: reg_rdata_out <= {32'h0000_0000, processor_status_r};
        exc_status_pkg::REG_CAUSE: reg_rdata_out <= {32'h0000_0000, exception_cause_r};
        exc_status_pkg::REG_EPC: reg_rdata_out <= exception_return_pc_r;
        exc_status_pkg::REG_XCTX: reg_rdata_out <= extended_pte_pointer_r;
        exc_status_pkg::REG_PARITY: reg_rdata_out <= {56'h0, cache_parity_override_r};
        default: reg_rdata_out <= 64'h0000_0000_0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 64'h0000_0000_0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode and registered outputs
  // ----------------------------------------------------------------------
  assign kernel = (privilege_mode_field == exc_status_pkg::KSU_KERNEL) || exception_level_bit || error_level_bit;
  assign sup_mode = (privilege_mode_field == exc_status_pkg::KSU_SUPER) && !exception_level_bit && !error_level_bit;
  assign user = (privilege_mode_field == exc_status_pkg::KSU_USER) && !exception_level_bit && !error_level_bit;

  // Outputs trail the status register by one cycle so each comes from a flop.
  always_ff @(posedge core_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      int_request_out <= 1'b0;
      kernel_mode_out <= 1'b1;
      super_mode_out <= 1'b0;
      user_mode_out <= 1'b0;
      addr64_out <= 1'b0;
      ops64_out <= 1'b1;
      kernel_space_ok_out <= 1'b1;
      super_space_ok_out <= 1'b1;
      user_space_ok_out <= 1'b1;
      useg_unmapped_out <= 1'b1;
      return_uses_error_pc_out <= 1'b1;
      refill_general_vector_out <= 1'b0;
      vector_bootstrap_out <= 1'b1;
      parity_exc_out <= 1'b0;
      parity_override_active_out <= 1'b0;
      parity_override_out <= 8'h00;
    end else begin
      int_request_out <= processor_status_r[exc_status_pkg::ST_IE] && !exception_level_bit && !error_level_bit &&
        |(processor_status_r[exc_status_pkg::ST_IM_LO +: 8] & exception_cause_r[exc_status_pkg::CA_IP_LO +: 8]);
      kernel_mode_out <= kernel;
      super_mode_out <= sup_mode;
      user_mode_out <= user;
      addr64_out <= (kernel && processor_status_r[exc_status_pkg::ST_KX]) ||
        (sup_mode && processor_status_r[exc_status_pkg::ST_SX]) || (user && processor_status_r[exc_status_pkg::ST_UX]);
      ops64_out <= kernel || (sup_mode && processor_status_r[exc_status_pkg::ST_SX]) ||
        (user && processor_status_r[exc_status_pkg::ST_UX]);
      kernel_space_ok_out <= kernel;
      super_space_ok_out <= kernel || sup_mode;
      user_space_ok_out <= 1'b1;
      useg_unmapped_out <= error_level_bit;
      return_uses_error_pc_out <= error_level_bit;
      refill_general_vector_out <= exception_level_bit;
      vector_bootstrap_out <= processor_status_r[exc_status_pkg::ST_BEV];
      parity_exc_out <= parity_err_in && !processor_status_r[exc_status_pkg::ST_DE];
      parity_override_active_out <= processor_status_r[exc_status_pkg::ST_CE];
      parity_override_out <= cache_parity_override_r;
    end
  end

endmodule : cpu_exception_status_regs

// >>> design/exc_status_pkg.sv
package exc_status_pkg;

  // ----------------------------------------------------------------------
  // Register numbers on the move port
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_CAUSE = 5'h0D;
  localparam logic [4:0] REG_EPC = 5'h0E;
  localparam logic [4:0] REG_XCTX = 5'h14;
  localparam logic [4:0] REG_PARITY = 5'h1A;

  // ----------------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------------
  localparam int ST_IE = 0;
  localparam int ST_EXL = 1;
  localparam int ST_ERL = 2;
  localparam int ST_KSU_LO = 3;
  localparam int ST_UX = 5;
  localparam int ST_SX = 6;
  localparam int ST_KX = 7;
  localparam int ST_IM_LO = 8;
  localparam int ST_DE = 16;
  localparam int ST_CE = 17;
  localparam int ST_SRF = 20;
  localparam int ST_BEV = 22;
  localparam logic [31:0] ST_WMASK = 32'h0057_FFFF;
  localparam logic [31:0] ST_RESET = 32'h0040_0004;

  // ----------------------------------------------------------------------
  // Privilege field codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] KSU_KERNEL = 2'h0;
  localparam logic [1:0] KSU_SUPER = 2'h1;
  localparam logic [1:0] KSU_USER = 2'h2;

  // ----------------------------------------------------------------------
  // Cause field positions
  // ----------------------------------------------------------------------
  localparam int CA_CODE_LO = 2;
  localparam int CA_IP_LO = 8;
  localparam int CA_CE_LO = 28;
  localparam int CA_BD = 31;

  // ----------------------------------------------------------------------
  // Extended page-table pointer field positions
  // ----------------------------------------------------------------------
  localparam int XC_VPN_LO = 4;
  localparam int XC_VPN_HI = 30;
  localparam int XC_R_LO = 31;
  localparam int XC_BASE_LO = 33;

  // ----------------------------------------------------------------------
  // Exception kinds and codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_GENERAL = 2'h0,
    KIND_CACHE_ERR = 2'h1,
    KIND_SOFT_RESET = 2'h2,
    KIND_NMI = 2'h3
  } exc_kind_t;

  localparam logic [4:0] EXC_INT = 5'h00;
  localparam logic [4:0] EXC_MOD = 5'h01;
  localparam logic [4:0] EXC_TLB_LOAD = 5'h02;
  localparam logic [4:0] EXC_TLB_STORE = 5'h03;
  localparam logic [4:0] EXC_ADDR_LOAD = 5'h04;
  localparam logic [4:0] EXC_ADDR_STORE = 5'h05;
  localparam logic [4:0] EXC_BUS_FETCH = 5'h06;
  localparam logic [4:0] EXC_BUS_DATA = 5'h07;
  localparam logic [4:0] EXC_SYSCALL = 5'h08;
  localparam logic [4:0] EXC_BREAK = 5'h09;
  localparam logic [4:0] EXC_RESV_INSTR = 5'h0A;
  localparam logic [4:0] EXC_COP_UNUSABLE = 5'h0B;
  localparam logic [4:0] EXC_OVERFLOW = 5'h0C;
  localparam logic [4:0] EXC_TRAP = 5'h0D;
  localparam logic [4:0] EXC_FLOAT = 5'h0F;

endpackage : exc_status_pkg

// >>> tb/exc_status_chk.sv
`timescale 1ns/1ns

module exc_status_chk (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic exc_take_in,
  input wire exc_status_pkg::exc_kind_t exc_kind_in,
  input wire logic parity_err_in,
  input wire logic int_request_out,
  input wire logic kernel_mode_out,
  input wire logic super_mode_out,
  input wire logic user_mode_out,
  input wire logic kernel_space_ok_out,
  input wire logic super_space_ok_out,
  input wire logic user_space_ok_out,
  input wire logic useg_unmapped_out,
  input wire logic return_uses_error_pc_out,
  input wire logic refill_general_vector_out,
  input wire logic vector_bootstrap_out,
  input wire logic parity_exc_out
);
  // ----------------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------------
  // Event checks look two edges on: one edge to update state, one for the registered outputs.
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  a_mode_onehot: assert property ($onehot({kernel_mode_out, super_mode_out, user_mode_out}))
    else $error("operating mode is not exactly one");
  a_levels_force_kernel: assert property ((refill_general_vector_out || useg_unmapped_out) |-> kernel_mode_out)
    else $error("level bit set outside kernel mode");
  a_space_perm: assert property (kernel_space_ok_out == kernel_mode_out && user_space_ok_out
    && super_space_ok_out == (kernel_mode_out || super_mode_out))
    else $error("address space permission wrong");
  a_int_blocked: assert property ((refill_general_vector_out || return_uses_error_pc_out) |-> !int_request_out)
    else $error("interrupt while a level bit is set");
  a_error_pc_useg: assert property (return_uses_error_pc_out == useg_unmapped_out)
    else $error("error return and unmapped user segment disagree");
  a_error_take: assert property (exc_take_in && exc_kind_in != exc_status_pkg::KIND_GENERAL
    |-> ##2 return_uses_error_pc_out)
    else $error("error class exception left error level clear");
  a_general_take: assert property (exc_take_in && exc_kind_in == exc_status_pkg::KIND_GENERAL
    |-> ##2 (refill_general_vector_out && !int_request_out))
    else $error("general exception left exception level clear");
  a_soft_boot: assert property (exc_take_in && exc_kind_in inside {exc_status_pkg::KIND_SOFT_RESET,
    exc_status_pkg::KIND_NMI} |-> ##2 vector_bootstrap_out)
    else $error("soft reset left normal vectors");
  a_parity_cause: assert property (!$past(parity_err_in) |-> !parity_exc_out)
    else $error("parity exception without parity error");
  c_nmi: cover property (exc_take_in && exc_kind_in == exc_status_pkg::KIND_NMI);
  c_int: cover property (int_request_out);
  c_parity: cover property (parity_exc_out);
endmodule : exc_status_chk

bind cpu_exception_status_regs exc_status_chk exc_status_chk_i (.*);

// >>> tb/test_cpu_exception_status_regs.sv
`timescale 1ns/1ns

module test_cpu_exception_status_regs;
  logic core_clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [4:0] reg_addr_in = 5'h00;
  logic [63:0] reg_wdata_in = 64'h0;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic exc_take_in = 1'h0;
  exc_status_pkg::exc_kind_t exc_kind_in = exc_status_pkg::KIND_GENERAL;
  logic [4:0] exc_code_in = 5'h00;
  logic exc_in_delay_in = 1'h0;
  logic [63:0] exc_pc_in = 64'h0;
  logic [63:0] exc_branch_pc_in = 64'h0;
  logic [1:0] exc_cop_in = 2'h0;
  logic tlb_miss_in = 1'h0;
  logic [63:0] exc_vaddr_in = 64'h0;
  logic exc_return_in = 1'h0;
  logic [5:0] ext_int_in = 6'h00;
  logic parity_err_in = 1'h0;
  logic index_load_tag_in = 1'h0;
  logic tag_op_data_in = 1'h0;
  logic [63:0] cache_dword_in = 64'h0;
  logic [63:0] reg_rdata_out;
  logic int_request_out, kernel_mode_out, super_mode_out, user_mode_out, addr64_out, ops64_out;
  logic kernel_space_ok_out, super_space_ok_out, user_space_ok_out, useg_unmapped_out;
  logic return_uses_error_pc_out, refill_general_vector_out, vector_bootstrap_out, parity_exc_out;
  logic parity_override_active_out;
  logic [7:0] parity_override_out;
  logic [6:0] mode_seen;
  logic [31:0] s;
  logic [63:0] w, e;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int j;

  assign mode_seen = {kernel_mode_out, super_mode_out, user_mode_out, addr64_out, ops64_out,
    kernel_space_ok_out, super_space_ok_out};

  cpu_exception_status_regs cpu_exception_status_regs_i (.*);

  always #5 core_clk_in = ~core_clk_in;

  // The whole run needs about 720 cycles; a hang is cut at 20000 cycles, far above that.
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // Bench tasks and expectations
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [63:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr

  task automatic rchk(input logic [4:0] a, input logic [63:0] exp, input string n);
    @(posedge core_clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'h0;
    #1;
    chk(n, reg_rdata_out, exp);
  endtask : rchk

  task automatic settle();
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask : settle

  task automatic take(input exc_status_pkg::exc_kind_t k, input logic [4:0] c, input logic t);
    @(posedge core_clk_in);
    exc_take_in <= 1'h1;
    exc_kind_in <= k;
    exc_code_in <= c;
    tlb_miss_in <= t;
    exc_in_delay_in <= 1'($urandom);
    exc_cop_in <= 2'($urandom);
    exc_pc_in <= {$urandom, $urandom};
    exc_branch_pc_in <= {$urandom, $urandom};
    exc_vaddr_in <= {$urandom, $urandom};
    @(posedge core_clk_in);
    exc_take_in <= 1'h0;
    #1;
  endtask : take

  task automatic strobe(input logic ret);
    @(posedge core_clk_in);
    exc_return_in <= ret;
    index_load_tag_in <= !ret;
    @(posedge core_clk_in);
    exc_return_in <= 1'h0;
    index_load_tag_in <= 1'h0;
  endtask : strobe

  function automatic logic [6:0] mode_exp(input logic [7:0] v);
    logic k, sv, u;
    k = v[4:3] == 2'h0 || v[1] || v[2];
    sv = !k && v[4:3] == 2'h1;
    u = !k && v[4:3] == 2'h2;
    return {k, sv, u, k ? v[7] : (sv ? v[6] : v[5]), k | (sv ? v[6] : v[5]), k, k | sv};
  endfunction : mode_exp

  function automatic logic [63:0] cause_exp(input logic [4:0] c);
    return {32'h0, exc_in_delay_in, 1'h0, (c == 5'h0B) ? exc_cop_in : 2'h0, 20'h0, 1'h0, c, 2'h0};
  endfunction : cause_exp

  function automatic logic [7:0] par_exp(input logic [63:0] d, input logic data);
    logic [7:0] p;
    for (int i = 0; i < 8; i++) p[i] = ^d[8 * i +: 8];
    return data ? p : {6'h00, ^d[63:32], ^d[31:0]};
  endfunction : par_exp

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    j = $urandom(32'hCE3759E4);
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge core_clk_in);
    rchk(5'h0C, 64'h0040_0004, "status reset");
    chk("boot outs", {kernel_mode_out, vector_bootstrap_out, useg_unmapped_out}, 64'h7);
    wr(5'h0D, '1);
    rchk(5'h0D, 64'h300, "cause write");
    w = {$urandom, $urandom};
    wr(5'h1F, w);
    rchk(5'h1F, 64'h0, "unmapped");
    wr(5'h0E, w);
    rchk(5'h0E, w, "epc rw");
    wr(5'h1A, w);
    rchk(5'h1A, {56'h0, w[7:0]}, "parity rw");
    $display("test registers done");
    repeat (48) begin
      s = $urandom & exc_status_pkg::ST_WMASK;
      s[4:3] = 2'($urandom_range(2, 0));
      wr(5'h0C, {32'h0, s});
      settle();
      chk("modes", mode_seen, mode_exp(s[7:0]));
      chk("levels", {refill_general_vector_out, useg_unmapped_out, return_uses_error_pc_out, user_space_ok_out},
        {s[1], s[2], s[2], 1'h1});
      chk("vec ovr", {vector_bootstrap_out, parity_override_active_out}, {s[22], s[17]});
    end
    $display("test modes done");
    for (int k = 0; k < 32; k++) begin
      j = (k % 4 < 2) ? k % 8 : $urandom_range(7, 0);
      s = (32'h1 << (8 + j)) | ((k % 2 == 1) ? 32'($urandom_range(7, 0)) : 32'h1);
      wr(5'h0D, (k % 8 < 2) ? 64'h100 << (k % 8) : 64'h0);
      ext_int_in <= (k % 8 < 2) ? 6'h00 : 6'h01 << (k % 8 - 2);
      wr(5'h0C, {32'h0, s});
      settle();
      chk("int", int_request_out, 64'(s[0] & !s[1] & !s[2] & (j == k % 8)));
    end
    @(posedge core_clk_in);
    ext_int_in <= 6'h00;
    wr(5'h0D, 64'h0);
    $display("test interrupts done");
    for (int c = 0; c < 16; c++) begin
      if (c == 14) continue;
      wr(5'h0C, 64'h0);
      take(exc_status_pkg::KIND_GENERAL, 5'(c), 1'h0);
      e = exc_in_delay_in ? exc_branch_pc_in : exc_pc_in;
      rchk(5'h0D, cause_exp(5'(c)), "cause");
      rchk(5'h0E, e, "epc");
      take(exc_status_pkg::KIND_GENERAL, 5'h0C, 1'h0);
      rchk(5'h0E, e, "epc held");
    end
    repeat (4) begin
      w = {$urandom, $urandom};
      wr(5'h14, w);
      take(exc_status_pkg::KIND_GENERAL, 5'h02, 1'h1);
      rchk(5'h14, {w[63:33], exc_vaddr_in[63:62], exc_vaddr_in[39:13], 4'h0}, "xctx");
    end
    e = cause_exp(5'h02);
    $display("test exceptions done");
    for (int k = 1; k < 4; k++) begin
      wr(5'h0C, 64'h0);
      wr(5'h0E, w);
      take(exc_status_pkg::exc_kind_t'(k), 5'h00, 1'h0);
      rchk(5'h0C, (k == 1) ? 64'h4 : 64'h0050_0004, "err status");
      rchk(5'h0D, e, "err cause");
      rchk(5'h0E, w, "err epc");
    end
    // A cold reset after a soft one must leave the soft reset flag clear.
    @(posedge core_clk_in);
    rst_b_in <= 1'h0;
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge core_clk_in);
    rchk(5'h0C, 64'h0040_0004, "cold after soft");
    wr(5'h0C, 64'h6);
    strobe(1'h1);
    rchk(5'h0C, 64'h2, "ret err");
    strobe(1'h1);
    rchk(5'h0C, 64'h0, "ret exc");
    $display("test error levels done");
    for (int k = 0; k < 2; k++) begin
      wr(5'h0C, 64'(k) << 16);
      parity_err_in <= 1'h1;
      settle();
      chk("par exc", parity_exc_out, 64'(k == 0));
      @(posedge core_clk_in);
      parity_err_in <= 1'h0;
    end
    repeat (8) begin
      @(posedge core_clk_in);
      tag_op_data_in <= 1'($urandom);
      cache_dword_in <= {$urandom, $urandom};
      strobe(1'h0);
      settle();
      chk("override", parity_override_out, par_exp(cache_dword_in, tag_op_data_in));
    end
    rchk(5'h1A, {56'h0, par_exp(cache_dword_in, tag_op_data_in)}, "override reg");
    $display("test parity done");
    tally_and_finish();
  end
endmodule : test_cpu_exception_status_regs
